// [tpms_pkg.sv]
// Constants and types for the triggered power measurement sequencer
// Function
// - Text result format selected delivers readable strings; text is the reset default.
// - Binary format delivers 32 or 64 bit elements; 32 bits after reset.
// - After reset sit idle, no measurement, until a start command arms.
// - Waiting for trigger holds until the selected source fires, then measures.
// - Finished measurement re-arms or returns idle according to the start mode.
// - Continuous start begins a fresh cycle as soon as the last completes.
// - One start command runs trigger-repeat-count cycles; count one gives one result.
// - Level trigger starts after configured delay once power crosses the reference.
// - Held or bus source triggers on remote command; bus also on common trigger.
// - Immediate source measures at once without any trigger condition.
// - Internal source derives its trigger from the measured input signal.
// - Two external trigger inputs: cable differential pair and separate coaxial connector.
// - Forced trigger bypasses the wait for held, internal, external and bus sources.
// - Repeating termination outputs one result after averaging-count repetitions.
// - Moving termination outputs a result after every partial measurement.
// - Average mode: noninverted then inverted phase, one aperture each; averaging count one runs the noninverted phase only.
// - Average mode repeating with sync on: sync high over whole averaged cycle.
// - Average mode moving: each measurement needs a trigger; sync high during each.
// - Results before the averaging count are flagged unsettled; settled afterwards.
// - When the trigger repeat count is reached, return to idle.
// - Trace mode: each chopper phase starts on its own trigger, one aperture long.
// - Trace mode with sync on: sync high only while a chopper phase runs.
// - Averaging count one: both terminations behave alike, settled data, then idle.
package tpms_pkg;
  // ****************************************
  // Trigger sources
  // ****************************************
  localparam logic [2:0] TPMS_SRC_HOLD = 3'h0;
  localparam logic [2:0] TPMS_SRC_IMM = 3'h1;
  localparam logic [2:0] TPMS_SRC_INT = 3'h2;
  localparam logic [2:0] TPMS_SRC_EXT1 = 3'h3;
  localparam logic [2:0] TPMS_SRC_EXT2 = 3'h4;
  localparam logic [2:0] TPMS_SRC_BUS = 3'h5;
  // ****************************************
  // Formats, modes and reset values
  // ****************************************
  localparam logic TPMS_FMT_TEXT = 1'b0;
  localparam logic TPMS_FMT_BIN = 1'b1;
  localparam logic TPMS_WIDTH_32 = 1'b0;
  localparam logic TPMS_WIDTH_64 = 1'b1;
  localparam logic TPMS_TERM_REPEAT = 1'b0;
  localparam logic TPMS_TERM_MOVING = 1'b1;
  localparam logic TPMS_MODE_AVG = 1'b0;
  localparam logic TPMS_MODE_TRACE = 1'b1;
  localparam logic TPMS_SLOPE_RISE = 1'b0;
  localparam int TPMS_CW = 16;
  localparam logic [TPMS_CW-1:0] TPMS_ONE = 16'h0001;
  localparam logic [TPMS_CW-1:0] TPMS_ZERO = 16'h0000;
  typedef enum logic [1:0] {TPMS_IDLE, TPMS_WAIT, TPMS_DELAY, TPMS_MEAS} tpms_state_e;
endpackage : tpms_pkg

// [tpms_seq.sv]
// Measurement sequencer with trigger selection, chopper phases and termination control
`timescale 1ns/1ps
module tpms_seq #(
  parameter int PW = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cmd_start,
  input wire logic cmd_abort,
  input wire logic start_continuous,
  input wire logic [tpms_pkg::TPMS_CW-1:0] trigger_repeat_count,
  input wire logic [2:0] trigger_source,
  input wire logic cmd_trigger,
  input wire logic cmd_common_trigger,
  input wire logic cmd_force_trigger,
  input wire logic ext1_trig_p,
  input wire logic ext1_trig_n,
  input wire logic ext2_trig,
  input wire logic [PW-1:0] signal_power,
  input wire logic [PW-1:0] trigger_level,
  input wire logic trigger_slope,
  input wire logic [tpms_pkg::TPMS_CW-1:0] trigger_delay,
  input wire logic [tpms_pkg::TPMS_CW-1:0] aperture_cycles,
  input wire logic [tpms_pkg::TPMS_CW-1:0] average_count,
  input wire logic meas_mode,
  input wire logic termination_control_select,
  input wire logic trace_termination_select,
  input wire logic sync_enable,
  input wire logic format_binary,
  input wire logic format_width64,
  output logic [1:0] seq_state,
  output logic chopper_active,
  output logic chopper_inverted,
  output logic trigger_sync,
  output logic result_valid,
  output logic result_settled,
  output logic result_binary,
  output logic result_width64
);
  import tpms_pkg::*;

  // ****************************************
  // Reset release and state
  // ****************************************
  logic rst_m, rst_s;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  tpms_state_e state;
  logic [TPMS_CW-1:0] tmr, avg_n, trig_n;
  logic phase_inv, ext1_q, ext2_q, above_q, armed_q;

  // ****************************************
  // Trigger selection
  // ****************************************
  wire logic ext1_lvl = ext1_trig_p & ~ext1_trig_n;
  wire logic ext1_edge = ext1_lvl & ~ext1_q;
  wire logic ext2_edge = ext2_trig & ~ext2_q;
  wire logic above = signal_power > trigger_level;
  wire logic level_edge = (trigger_slope == TPMS_SLOPE_RISE) ? (above & ~above_q)
                          : (~above & above_q);
  wire logic src_event =
      (trigger_source == TPMS_SRC_HOLD) ? cmd_trigger :
      (trigger_source == TPMS_SRC_BUS) ? (cmd_trigger | cmd_common_trigger) :
      (trigger_source == TPMS_SRC_IMM) ? 1'b1 :
      (trigger_source == TPMS_SRC_INT) ? level_edge :
      (trigger_source == TPMS_SRC_EXT1) ? ext1_edge :
      (trigger_source == TPMS_SRC_EXT2) ? ext2_edge : 1'b0;
  wire logic forced = cmd_force_trigger & (trigger_source != TPMS_SRC_IMM);
  wire logic use_delay = (trigger_source == TPMS_SRC_INT) & ~forced
                         & (trigger_delay != TPMS_ZERO);
  wire logic fire = src_event | forced;

  // ****************************************
  // Termination and sequencing decisions
  // ****************************************
  wire logic term_moving = (meas_mode == TPMS_MODE_TRACE) ?
      (trace_termination_select == TPMS_TERM_MOVING) :
      (termination_control_select == TPMS_TERM_MOVING);
  wire logic [TPMS_CW-1:0] avg_eff = (average_count == TPMS_ZERO) ? TPMS_ONE : average_count;
  wire logic single_ap = (avg_eff == TPMS_ONE);
  wire logic [TPMS_CW-1:0] ap_eff = (aperture_cycles == TPMS_ZERO) ? TPMS_ONE : aperture_cycles;
  wire logic ap_done = (tmr == ap_eff - TPMS_ONE);
  // Measurement complete: single aperture for count one, else after the inverted phase
  wire logic meas_done = ap_done & (single_ap | phase_inv);
  wire logic [TPMS_CW-1:0] avg_next = (avg_n == 16'hFFFF) ? avg_n : avg_n + TPMS_ONE;
  wire logic avg_reached = (avg_next >= avg_eff);
  // Repeating: result only after count repetitions; moving: every measurement
  wire logic emit = meas_done & (term_moving | avg_reached | single_ap);
  // Repeating with count above one keeps measuring without a new trigger in average mode
  wire logic chain = (state == TPMS_MEAS) & meas_done & ~emit
                     & (meas_mode == TPMS_MODE_AVG);
  wire logic cycle_done = emit & ~term_moving | emit & term_moving;
  wire logic [TPMS_CW-1:0] trig_next = trig_n + TPMS_ONE;
  wire logic [TPMS_CW-1:0] rep_eff = (trigger_repeat_count == TPMS_ZERO) ? TPMS_ONE
                                     : trigger_repeat_count;
  wire logic reps_done = (trig_next >= rep_eff) & ~start_continuous;
  // Trace mode waits for a trigger before each chopper phase
  wire logic phase_trig = ap_done & ~meas_done & (meas_mode == TPMS_MODE_TRACE);

  // ****************************************
  // State machine
  // ****************************************
  tpms_state_e next_state;
  always_comb begin
    next_state = state;
    case (state)
      TPMS_IDLE: begin
        if (cmd_start | start_continuous) begin
          next_state = TPMS_WAIT;
        end
      end
      TPMS_WAIT: begin
        if (fire) begin
          next_state = use_delay ? TPMS_DELAY : TPMS_MEAS;
        end
      end
      TPMS_DELAY: begin
        if (tmr == trigger_delay - TPMS_ONE) begin
          next_state = TPMS_MEAS;
        end
      end
      TPMS_MEAS: begin
        if (phase_trig) begin
          next_state = TPMS_WAIT;
        end else if (meas_done & ~chain) begin
          // Moving in average mode and trace mode need a fresh trigger each measurement
          // Repeat count ends the run even before a moving average has settled
          if (cycle_done & reps_done) begin
            next_state = TPMS_IDLE;
          end else begin
            next_state = TPMS_WAIT;
          end
        end
      end
      default: next_state = TPMS_IDLE;
    endcase
    if (cmd_abort) begin
      next_state = TPMS_IDLE;
    end
  end

  wire logic enter_meas = (state != TPMS_MEAS) & (next_state == TPMS_MEAS);
  wire logic new_cycle = (state == TPMS_IDLE) & (next_state == TPMS_WAIT);
  wire logic in_meas_next = (next_state == TPMS_MEAS);
  // Sync: whole averaged cycle in repeating average mode, else each measurement or phase
  wire logic next_sync = sync_enable & in_meas_next;

  always_ff @(posedge clk_sys or negedge rst_s) begin
    if (!rst_s) begin
      state <= TPMS_IDLE;
      tmr <= TPMS_ZERO;
      phase_inv <= 1'b0;
      avg_n <= TPMS_ZERO;
      trig_n <= TPMS_ZERO;
      ext1_q <= 1'b0;
      ext2_q <= 1'b0;
      above_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      state <= next_state;
      ext1_q <= ext1_lvl;
      ext2_q <= ext2_trig;
      above_q <= above;
      armed_q <= (next_state != TPMS_IDLE);
      if (enter_meas | (state == TPMS_MEAS & ap_done) | (state != next_state)) begin
        tmr <= TPMS_ZERO;
      end else begin
        tmr <= tmr + TPMS_ONE;
      end
      if (state == TPMS_MEAS & ap_done) begin
        phase_inv <= ~phase_inv & ~meas_done;
      end else if (new_cycle) begin
        phase_inv <= 1'b0;
      end
      if (new_cycle) begin
        avg_n <= TPMS_ZERO;
        trig_n <= TPMS_ZERO;
      end else if (state == TPMS_MEAS & meas_done) begin
        avg_n <= (emit & ~term_moving) ? TPMS_ZERO : avg_next;
        if (emit) begin
          trig_n <= trig_next;
        end
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_s) begin
    if (!rst_s) begin
      seq_state <= 2'h0;
      chopper_active <= 1'b0;
      chopper_inverted <= 1'b0;
      trigger_sync <= 1'b0;
      result_valid <= 1'b0;
      result_settled <= 1'b0;
      result_binary <= TPMS_FMT_TEXT;
      result_width64 <= TPMS_WIDTH_32;
    end else begin
      seq_state <= next_state;
      chopper_active <= in_meas_next;
      chopper_inverted <= in_meas_next & phase_inv;
      trigger_sync <= next_sync;
      result_valid <= (state == TPMS_MEAS) & emit;
      result_settled <= (state == TPMS_MEAS) & emit & (avg_reached | single_ap);
      result_binary <= format_binary;
      result_width64 <= format_binary & format_width64;
    end
  end

endmodule : tpms_seq

// [tpms_seq_asserts.sv]
// Port-level assertions for the measurement sequencer
`timescale 1ns/1ps
module tpms_seq_chk import tpms_pkg::*; (
  input wire logic clk_sys, rst_b, cmd_start, cmd_abort, cmd_trigger, cmd_force_trigger,
  input wire logic [2:0] trigger_source,
  input wire logic meas_mode, sync_enable, format_binary, format_width64,
  input wire logic [1:0] seq_state,
  input wire logic chopper_active, chopper_inverted, trigger_sync,
  input wire logic result_valid, result_settled, result_binary, result_width64
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  start_arms_a: assert property (seq_state == 2'h0 && cmd_start && !cmd_abort |=> seq_state == 2'h1)
    else $error("start did not arm");
  hold_waits_a: assert property (seq_state == 2'h1 && trigger_source == TPMS_SRC_HOLD && !cmd_trigger
    && !cmd_force_trigger && !cmd_abort |=> seq_state == 2'h1)
    else $error("left wait without trigger");
  imm_fires_a: assert property (seq_state == 2'h1 && trigger_source == TPMS_SRC_IMM && !cmd_abort
    |=> seq_state == 2'h3) else $error("immediate did not measure");
  force_fires_a: assert property (seq_state == 2'h1 && cmd_force_trigger && !cmd_abort
    && trigger_source != TPMS_SRC_IMM |=> seq_state == 2'h3) else $error("force ignored");
  idle_quiet_a: assert property (seq_state == 2'h0 |-> !chopper_active && !trigger_sync)
    else $error("activity while idle");
  sync_off_a: assert property (!sync_enable && !$past(sync_enable) |-> !trigger_sync)
    else $error("sync high while disabled");
  trace_sync_a: assert property (meas_mode == TPMS_MODE_TRACE && trigger_sync |-> chopper_active)
    else $error("trace sync outside phase");
  phase_order_a: assert property (meas_mode == TPMS_MODE_AVG && $rose(chopper_inverted)
    |-> $past(chopper_active)) else $error("inverted phase not chained");
  valid_pulse_a: assert property (result_valid |=> !result_valid) else $error("valid too long");
  settled_valid_a: assert property (result_settled |-> result_valid) else $error("stray settled");
  format_out_a: assert property (result_valid |-> result_binary == format_binary
    && result_width64 == (format_binary && format_width64)) else $error("format wrong");
  cover property (result_valid && result_settled);
  cover property (result_valid && !result_settled);
  cover property (trigger_sync && chopper_inverted);
endmodule : tpms_seq_chk
bind tpms_seq tpms_seq_chk i_chk (.*);

// [tpms_trig_src.sv]
// Model of the two external trigger generators
`timescale 1ns/1ps
module tpms_trig_src (
  input wire logic clk_sys,
  input wire logic fire1,
  input wire logic fire2,
  output logic ext1_trig_p,
  output logic ext1_trig_n,
  output logic ext2_trig
);
  int left1 = 0;
  int left2 = 0;
  // Two-cycle pulse per event so every event gives one rising edge
  always @(negedge clk_sys) begin
    left1 = fire1 ? 2 : (left1 > 0 ? left1 - 1 : 0);
    left2 = fire2 ? 2 : (left2 > 0 ? left2 - 1 : 0);
  end
  assign ext1_trig_p = left1 > 0;
  assign ext1_trig_n = left1 == 0;
  assign ext2_trig = left2 > 0;
endmodule : tpms_trig_src

// [tb_top.sv]
// Self-checking bench for the measurement sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
  import tpms_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, cmd_start = 1'b0, cmd_abort = 1'b0, start_continuous = 1'b0;
  logic cmd_trigger = 1'b0, cmd_common_trigger = 1'b0, cmd_force_trigger = 1'b0;
  logic trigger_slope = 1'b0, meas_mode = 1'b0, sync_enable = 1'b1, fire1 = 1'b0, fire2 = 1'b0;
  logic termination_control_select = 1'b0, trace_termination_select = 1'b0;
  logic format_binary = 1'b0, format_width64 = 1'b0;
  logic [2:0] trigger_source = 3'h1;
  logic [15:0] trigger_repeat_count = 16'h0001, trigger_delay = 16'h0002;
  logic [15:0] aperture_cycles = 16'h0002, average_count = 16'h0001;
  logic [15:0] signal_power = 16'h0000, trigger_level = 16'h0100;
  logic ext1_trig_p, ext1_trig_n, ext2_trig, chopper_active, chopper_inverted, trigger_sync;
  logic result_valid, result_settled, result_binary, result_width64;
  logic [1:0] seq_state;
  int miscompares = 0, comparisons = 0, cyc = 0;
  bit exp_q[$];
  tpms_seq i_dut (.*);
  tpms_trig_src i_src (.*);
  always #2.5 clk_sys = ~clk_sys;
  // Input power swings across the level every eight cycles
  always @(negedge clk_sys) begin
    cyc++;
    signal_power <= (cyc % 8 < 4) ? 16'h0000 : 16'h0200;
  end
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // One armed run; kind picks the trigger stimulus, the queue holds expected settled flags
  task automatic run(input logic [2:0] src, input int kind, mode, term, avg, rep, cont);
    int guard;
    bit go;
    bit exp_s;
    trigger_source = src;
    meas_mode = mode[0];
    termination_control_select = term[0];
    trace_termination_select = term[0];
    average_count = 16'(avg);
    trigger_repeat_count = cont ? 16'h0001 : 16'(rep);
    aperture_cycles = 16'($urandom_range(4, 2));
    sync_enable = 1'($urandom);
    format_binary = 1'($urandom);
    format_width64 = 1'($urandom);
    for (int i = 0; i < rep; i++) exp_q.push_back(term == 0 || i + 1 >= avg);
    start_continuous = cont[0];
    cmd_start = 1'b1;
    for (guard = 0; guard < 4000 && exp_q.size() > 0; guard++) begin
      @(negedge clk_sys);
      go = seq_state == 2'h1 && guard % 4 == 1;
      cmd_start = 1'b0;
      cmd_trigger = go && kind == 1;
      cmd_common_trigger = go && kind == 2;
      cmd_force_trigger = go && kind == 3;
      fire1 <= go && kind == 4;
      fire2 <= go && kind == 5;
      @(posedge clk_sys);
      #1;
      if (result_valid === 1'b1) begin
        exp_s = exp_q.pop_front();
        `CHK(result_settled, exp_s)
        `CHK(result_binary, format_binary)
        `CHK(result_width64, format_binary & format_width64)
      end
    end
    @(negedge clk_sys);
    {cmd_trigger, cmd_common_trigger, cmd_force_trigger} = 3'h0;
    {fire1, fire2} <= 2'h0;
    start_continuous = 1'b0;
    cmd_abort = cont[0];
    @(negedge clk_sys);
    cmd_abort = 1'b0;
    @(negedge clk_sys);
    `CHK(seq_state, 2'h0)
    `CHK(guard < 4000, 1'b1)
    exp_q.delete();
  endtask : run
  initial begin
    void'($urandom(32'hAD9E410C));
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK(seq_state, 2'h0)
    `CHK({result_binary, result_width64}, 2'h0)
    run(TPMS_SRC_IMM, 0, 0, 0, 1, 1, 0);
    run(TPMS_SRC_IMM, 0, 0, 0, 3, 2, 0);
    run(TPMS_SRC_BUS, 2, 0, 1, 3, 5, 0);
    run(TPMS_SRC_HOLD, 1, 0, 1, 1, 2, 0);
    run(TPMS_SRC_INT, 3, 1, 0, 2, 2, 0);
    run(TPMS_SRC_EXT1, 4, 1, 1, 2, 3, 0);
    run(TPMS_SRC_EXT2, 5, 0, 1, 2, 2, 0);
    run(TPMS_SRC_INT, 0, 0, 0, 1, 2, 0);
    run(TPMS_SRC_IMM, 0, 0, 0, 1, 3, 1);
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end
endmodule : tb_top
